//--- design/abe_regs.vh
`ifndef ABE_REGS_VH
`define ABE_REGS_VH

// ----------------------------------------------------------------
// Bus map (byte addresses)
// ----------------------------------------------------------------
`define ABE_ADR_OP        12'h000
`define ABE_ADR_PC        12'h004
`define ABE_ADR_SREG      12'h008
`define ABE_ADR_STATUS    12'h00C
`define ABE_ADR_RET       12'h010
`define ABE_RGN_GPR       4'h1
`define ABE_RGN_IO        4'h2

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define ABE_F_OP_LSB      0
`define ABE_F_RD_LSB      6
`define ABE_F_RR_LSB      11
`define ABE_F_BIT_LSB     17
`define ABE_F_LONG        20
`define ABE_F_K_LSB       21

// ----------------------------------------------------------------
// Status flag positions and low bit-addressable I/O limit
// ----------------------------------------------------------------
`define ABE_FLG_C         0
`define ABE_FLG_Z         1
`define ABE_FLG_N         2
`define ABE_FLG_V         3
`define ABE_FLG_S         4
`define ABE_FLG_H         5
`define ABE_IO_BIT_MAX    6'h1F
`define ABE_SREG_RST      8'h00
`define ABE_PC_RST        16'h0000

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define ABE_OP_ADD        6'h00
`define ABE_OP_ADC        6'h01
`define ABE_OP_SUB        6'h02
`define ABE_OP_SUBK       6'h03
`define ABE_OP_SUBC       6'h04
`define ABE_OP_SUBCK      6'h05
`define ABE_OP_AND        6'h06
`define ABE_OP_ANDK       6'h07
`define ABE_OP_OR         6'h08
`define ABE_OP_ORK        6'h09
`define ABE_OP_XOR        6'h0A
`define ABE_OP_CLRBITS    6'h0B
`define ABE_OP_TEST       6'h0C
`define ABE_OP_WADD       6'h0D
`define ABE_OP_WSUB       6'h0E
`define ABE_OP_CMP        6'h0F
`define ABE_OP_CMPC       6'h10
`define ABE_OP_CMPK       6'h11
`define ABE_OP_CMPSKIP    6'h12
`define ABE_OP_RBCSKIP    6'h13
`define ABE_OP_RBSSKIP    6'h14
`define ABE_OP_IOCSKIP    6'h15
`define ABE_OP_IOSSKIP    6'h16
`define ABE_OP_IOSET      6'h17
`define ABE_OP_IOCLR      6'h18
`define ABE_OP_RJUMP      6'h19
`define ABE_OP_RELCALL    6'h1A
`define ABE_OP_PJUMP      6'h1B
`define ABE_OP_PCALL      6'h1C
`define ABE_OP_BRFS       6'h1D
`define ABE_OP_BRFC       6'h1E
`define ABE_OP_BRZSET     6'h1F
`define ABE_OP_BRZCLR     6'h20
`define ABE_OP_BRCSET     6'h21
`define ABE_OP_BRCCLR     6'h22
`define ABE_OP_BRHIS      6'h23
`define ABE_OP_BRLOW      6'h24

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define ABE_CYC_1         2'd1
`define ABE_CYC_2         2'd2
`define ABE_CYC_3         2'd3

`endif

//--- design/abe_exec.v
// Contract
// - Bit set, clear and test-skip work only on I/O addresses 0x00 to 0x1F.
// - I/O bit set or clear changes the addressed bit and nothing else.
// - I/O bit-test skips skip on clear or set bit, taking 1, 2 or 3 cycles.
// - Add and add-with-carry store the sum, update Z C N V H, one cycle.
// - Word add and subtract immediate on a pair, update Z C N V S, two cycles.
// - Subtract forms store difference, less carry in the carry forms, update Z C N V H, one cycle.
// - AND, OR, XOR store result in one cycle, update Z N V only.
// - Clear-bits ANDs with 0xFF minus constant, updates Z N V.
// - Test ANDs a register with itself in one cycle, updates Z N V.
// - Relative call loads PC plus offset plus one in 3 cycles, jump in 2.
// - Pointer jump and call load PC from the pointer pair, 2 and 3 cycles.
// - Compare-skip-equal advances PC by 2 or 3 when equal, no flag changes.
// - Compare forms update Z N V C H without storing, one cycle.
// - Register bit-test skips skip on clear or set bit, 1, 2 or 3 cycles.
// - Flag branch loads PC plus offset plus one if true, 1 or 2 cycles.
// - Equal branches test Z, carry branches test C, same timing.
// - Same-or-higher branches on C clear, lower on C set.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "abe_regs.vh"

module abe_exec (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [11:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0]  gpr_q [0:31];
  reg  [7:0]  io_q  [0:63];
  reg  [15:0] pc_q;
  reg  [15:0] ret_q;
  reg  [7:0]  sreg_q;
  reg  [1:0]  cnt_q;
  reg  [1:0]  last_cyc_q;
  reg         taken_q;
  reg         bad_q;
  integer     i;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        req     = cyc_i & stb_i & ~ack_o;
  wire        wr_req  = req & we_i;
  wire        busy    = (cnt_q != 2'd0);
  wire        is_gpr  = (adr_i[11:8] == `ABE_RGN_GPR) & ~adr_i[7];
  wire        is_io   = (adr_i[11:8] == `ABE_RGN_IO);
  wire        launch  = wr_req & (adr_i == `ABE_ADR_OP) & ~busy;

  // ----------------------------------------------------------------
  // Command fields
  // ----------------------------------------------------------------
  wire [5:0]  op      = dat_i[`ABE_F_OP_LSB +: 6];
  wire [4:0]  rd      = dat_i[`ABE_F_RD_LSB +: 5];
  wire [4:0]  rr      = dat_i[`ABE_F_RR_LSB +: 5];
  wire [5:0]  io_adr  = dat_i[`ABE_F_RR_LSB +: 6];
  wire [2:0]  bsel    = dat_i[`ABE_F_BIT_LSB +: 3];
  wire        nx_long = dat_i[`ABE_F_LONG];
  wire [10:0] koff    = dat_i[`ABE_F_K_LSB +: 11];
  wire [7:0]  kc      = dat_i[`ABE_F_K_LSB +: 8];
  wire [15:0] kw      = {10'h0, dat_i[`ABE_F_K_LSB +: 6]};
  // Sign extension lets targets fall before the current instruction
  wire [15:0] koff16  = {{5{koff[10]}}, koff};

  // ----------------------------------------------------------------
  // Shared 8-bit adder and subtractor
  // ----------------------------------------------------------------
  wire [7:0]  opa     = gpr_q[rd];
  wire [7:0]  opr     = gpr_q[rr];
  wire        use_k   = (op == `ABE_OP_SUBK) | (op == `ABE_OP_SUBCK) | (op == `ABE_OP_ANDK) |
                        (op == `ABE_OP_ORK) | (op == `ABE_OP_CMPK);
  wire        use_c   = (op == `ABE_OP_ADC) | (op == `ABE_OP_SUBC) | (op == `ABE_OP_SUBCK) |
                        (op == `ABE_OP_CMPC);
  wire [7:0]  opb     = use_k ? kc : opr;
  wire [8:0]  cin9    = {8'h00, use_c & sreg_q[`ABE_FLG_C]};
  wire [8:0]  sum9    = {1'b0, opa} + {1'b0, opb} + cin9;
  wire [8:0]  dif9    = {1'b0, opa} - {1'b0, opb} - cin9;
  wire [7:0]  sr      = sum9[7:0];
  wire [7:0]  dr      = dif9[7:0];
  wire        add_h   = (opa[3] & opb[3]) | (opb[3] & ~sr[3]) | (~sr[3] & opa[3]);
  wire        add_v   = (opa[7] & opb[7] & ~sr[7]) | (~opa[7] & ~opb[7] & sr[7]);
  wire        sub_h   = (~opa[3] & opb[3]) | (opb[3] & dr[3]) | (dr[3] & ~opa[3]);
  wire        sub_v   = (opa[7] & ~opb[7] & ~dr[7]) | (~opa[7] & opb[7] & dr[7]);
  // Carry forms keep Z only if the earlier byte was zero too, for multi-byte chains
  wire        sub_z   = (dr == 8'h00) & (~use_c | sreg_q[`ABE_FLG_Z]);

  // ----------------------------------------------------------------
  // Word pair arithmetic
  // ----------------------------------------------------------------
  wire [4:0]  rdl     = {rd[4:1], 1'b0};
  wire [4:0]  rdh     = {rd[4:1], 1'b1};
  wire [15:0] wop     = {gpr_q[rdh], gpr_q[rdl]};
  wire [15:0] wsum    = wop + kw;
  wire [15:0] wdif    = wop - kw;
  wire [15:0] ptr     = {gpr_q[5'd31], gpr_q[5'd30]};
  wire [15:0] pc_rel  = pc_q + koff16 + 16'h0001;
  wire [15:0] pc_skip = pc_q + (nx_long ? 16'h0003 : 16'h0002);
  wire [7:0]  io_val  = io_q[io_adr];
  wire        io_low  = (io_adr <= `ABE_IO_BIT_MAX);

  // ----------------------------------------------------------------
  // Execution decode
  // ----------------------------------------------------------------
  reg  [7:0]  res8;
  reg         wr8;
  reg  [15:0] res16;
  reg         wr16;
  reg  [7:0]  nx_sreg;
  reg  [15:0] nx_pc;
  reg  [1:0]  nx_cyc;
  reg         io_wr;
  reg         io_bit;
  reg         skip;
  reg         brc;
  reg         call;
  reg         bad;

  // One decoder produces every effect; all of it commits on the launch edge
  always @* begin
    res8    = 8'h00;
    wr8     = 1'b0;
    res16   = 16'h0000;
    wr16    = 1'b0;
    nx_sreg = sreg_q;
    nx_pc   = pc_q + 16'h0001;
    nx_cyc  = `ABE_CYC_1;
    io_wr   = 1'b0;
    io_bit  = 1'b0;
    skip    = 1'b0;
    brc     = 1'b0;
    call    = 1'b0;
    bad     = 1'b0;
    case (op)
      `ABE_OP_ADD, `ABE_OP_ADC: begin
        res8 = sr;
        wr8  = 1'b1;
        nx_sreg[`ABE_FLG_Z] = (sr == 8'h00);
        nx_sreg[`ABE_FLG_C] = sum9[8];
        nx_sreg[`ABE_FLG_N] = sr[7];
        nx_sreg[`ABE_FLG_V] = add_v;
        nx_sreg[`ABE_FLG_H] = add_h;
      end
      `ABE_OP_SUB, `ABE_OP_SUBK, `ABE_OP_SUBC, `ABE_OP_SUBCK,
      `ABE_OP_CMP, `ABE_OP_CMPC, `ABE_OP_CMPK: begin
        res8 = dr;
        // Compares share the subtractor but never store
        wr8  = (op != `ABE_OP_CMP) & (op != `ABE_OP_CMPC) & (op != `ABE_OP_CMPK);
        nx_sreg[`ABE_FLG_Z] = sub_z;
        nx_sreg[`ABE_FLG_C] = dif9[8];
        nx_sreg[`ABE_FLG_N] = dr[7];
        nx_sreg[`ABE_FLG_V] = sub_v;
        nx_sreg[`ABE_FLG_H] = sub_h;
      end
      `ABE_OP_AND, `ABE_OP_ANDK, `ABE_OP_OR, `ABE_OP_ORK,
      `ABE_OP_XOR, `ABE_OP_CLRBITS, `ABE_OP_TEST: begin
        if ((op == `ABE_OP_AND) | (op == `ABE_OP_ANDK)) begin
          res8 = opa & opb;
        end else if ((op == `ABE_OP_OR) | (op == `ABE_OP_ORK)) begin
          res8 = opa | opb;
        end else if (op == `ABE_OP_XOR) begin
          res8 = opa ^ opr;
        end else if (op == `ABE_OP_CLRBITS) begin
          res8 = opa & (8'hFF - kc);
        end else begin
          res8 = opa & opa;
        end
        wr8 = 1'b1;
        // Carry and half carry stay as they were
        nx_sreg[`ABE_FLG_Z] = (res8 == 8'h00);
        nx_sreg[`ABE_FLG_N] = res8[7];
        nx_sreg[`ABE_FLG_V] = 1'b0;
      end
      `ABE_OP_WADD, `ABE_OP_WSUB: begin
        res16  = (op == `ABE_OP_WADD) ? wsum : wdif;
        wr16   = 1'b1;
        nx_cyc = `ABE_CYC_2;
        nx_sreg[`ABE_FLG_Z] = (res16 == 16'h0000);
        nx_sreg[`ABE_FLG_N] = res16[15];
        if (op == `ABE_OP_WADD) begin
          nx_sreg[`ABE_FLG_V] = ~wop[15] & res16[15];
          nx_sreg[`ABE_FLG_C] = ~res16[15] & wop[15];
        end else begin
          nx_sreg[`ABE_FLG_V] = wop[15] & ~res16[15];
          nx_sreg[`ABE_FLG_C] = res16[15] & ~wop[15];
        end
        nx_sreg[`ABE_FLG_S] = nx_sreg[`ABE_FLG_N] ^ nx_sreg[`ABE_FLG_V];
      end
      `ABE_OP_CMPSKIP: begin
        skip = (opa == opr);
      end
      `ABE_OP_RBCSKIP, `ABE_OP_RBSSKIP: begin
        skip = (opr[bsel] == (op == `ABE_OP_RBSSKIP));
      end
      `ABE_OP_IOCSKIP, `ABE_OP_IOSSKIP: begin
        bad  = ~io_low;
        skip = io_low & (io_val[bsel] == (op == `ABE_OP_IOSSKIP));
      end
      `ABE_OP_IOSET, `ABE_OP_IOCLR: begin
        bad    = ~io_low;
        io_wr  = io_low;
        io_bit = (op == `ABE_OP_IOSET);
        nx_cyc = `ABE_CYC_2;
      end
      `ABE_OP_RJUMP, `ABE_OP_RELCALL: begin
        nx_pc  = pc_rel;
        call   = (op == `ABE_OP_RELCALL);
        nx_cyc = call ? `ABE_CYC_3 : `ABE_CYC_2;
      end
      `ABE_OP_PJUMP, `ABE_OP_PCALL: begin
        nx_pc  = ptr;
        call   = (op == `ABE_OP_PCALL);
        nx_cyc = call ? `ABE_CYC_3 : `ABE_CYC_2;
      end
      `ABE_OP_BRFS, `ABE_OP_BRFC: begin
        brc = (sreg_q[bsel] == (op == `ABE_OP_BRFS));
      end
      `ABE_OP_BRZSET, `ABE_OP_BRZCLR: begin
        brc = (sreg_q[`ABE_FLG_Z] == (op == `ABE_OP_BRZSET));
      end
      `ABE_OP_BRCSET, `ABE_OP_BRCCLR: begin
        brc = (sreg_q[`ABE_FLG_C] == (op == `ABE_OP_BRCSET));
      end
      `ABE_OP_BRHIS, `ABE_OP_BRLOW: begin
        brc = (sreg_q[`ABE_FLG_C] == (op == `ABE_OP_BRLOW));
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    // Skipping a two-word instruction costs one more cycle
    if (skip) begin
      nx_pc  = pc_skip;
      nx_cyc = nx_long ? `ABE_CYC_3 : `ABE_CYC_2;
    end
    if (brc) begin
      nx_pc  = pc_rel;
      nx_cyc = `ABE_CYC_2;
    end
    // An unknown or out-of-range command leaves registers, I/O, SREG, PC and return address alone; only the status word records it
    if (bad) begin
      wr8     = 1'b0;
      io_wr   = 1'b0;
      nx_sreg = sreg_q;
      nx_pc   = pc_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file, I/O space and core state
  // ----------------------------------------------------------------
  // Bus writes and command effects share one process so each array has a single driver
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr_q[i] <= 8'h00;
      end
      for (i = 0; i < 64; i = i + 1) begin
        io_q[i] <= 8'h00;
      end
      pc_q       <= `ABE_PC_RST;
      ret_q      <= `ABE_PC_RST;
      sreg_q     <= `ABE_SREG_RST;
      cnt_q      <= 2'd0;
      last_cyc_q <= 2'd0;
      taken_q    <= 1'b0;
      bad_q      <= 1'b0;
    end else begin
      if (busy) begin
        cnt_q <= cnt_q - 2'd1;
      end
      if (launch) begin
        cnt_q      <= nx_cyc - 2'd1;
        last_cyc_q <= nx_cyc;
        taken_q    <= skip | brc;
        bad_q      <= bad;
        sreg_q     <= nx_sreg;
        pc_q       <= nx_pc;
        if (call & ~bad) begin
          ret_q <= pc_q + 16'h0001;
        end
        if (wr8) begin
          gpr_q[rd] <= res8;
        end
        if (wr16) begin
          gpr_q[rdl] <= res16[7:0];
          gpr_q[rdh] <= res16[15:8];
        end
        // Only the addressed bit moves; write-one-to-clear neighbours stay untouched
        if (io_wr) begin
          io_q[io_adr][bsel] <= io_bit;
        end
      end else if (wr_req & ~busy) begin
        if ((adr_i == `ABE_ADR_PC) & sel_i[0]) begin
          pc_q[7:0] <= dat_i[7:0];
        end
        if ((adr_i == `ABE_ADR_PC) & sel_i[1]) begin
          pc_q[15:8] <= dat_i[15:8];
        end
        if ((adr_i == `ABE_ADR_SREG) & sel_i[0]) begin
          sreg_q <= dat_i[7:0];
        end
        if (is_gpr & sel_i[0]) begin
          gpr_q[adr_i[6:2]] <= dat_i[7:0];
        end
        if (is_io & sel_i[0]) begin
          io_q[adr_i[7:2]] <= dat_i[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  // Ack is one registered cycle; unmapped reads return zero and writes are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      dat_o <= 32'h00000000;
      if (req & ~we_i) begin
        if (adr_i == `ABE_ADR_PC) begin
          dat_o <= {16'h0000, pc_q};
        end else if (adr_i == `ABE_ADR_SREG) begin
          dat_o <= {24'h000000, sreg_q};
        end else if (adr_i == `ABE_ADR_STATUS) begin
          dat_o <= {26'h0, bad_q, taken_q, last_cyc_q, 1'b0, busy};
        end else if (adr_i == `ABE_ADR_RET) begin
          dat_o <= {16'h0000, ret_q};
        end else if (is_gpr) begin
          dat_o <= {24'h000000, gpr_q[adr_i[6:2]]};
        end else if (is_io) begin
          dat_o <= {24'h000000, io_q[adr_i[7:2]]};
        end
      end
    end
  end

endmodule // abe_exec

//--- test/abe_exec_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Bus answer checker
// ----------------------------------------------------------------
module abe_exec_props (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus requests
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [11:0] adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  // Bus answers
  input wire [31:0] dat_o,
  input wire        ack_o
);
  // A fresh request and the holes in the address map
  wire req = cyc_i && stb_i && !ack_o;
  wire hole = (adr_i > 12'h010 && adr_i < 12'h100) || (adr_i >= 12'h180 && adr_i < 12'h200) || adr_i >= 12'h300;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Handshake timing is fixed at one cycle
  a_ack_next_cycle: assert property (req |=> ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  a_no_idle_ack: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack while idle");
  // Read data is quiet outside the answer cycle
  a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0) else $error("busy after reset");
  a_hole_reads_zero: assert property (req && !we_i && hole |=> dat_o == 32'h0) else $error("hole not zero");
  a_status_spare: assert property (req && !we_i && adr_i == 12'h00C |=> !dat_o[1]) else $error("status spare set");
endmodule // abe_exec_props

bind abe_exec abe_exec_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

//--- test/alu_branch_execute_bench.sv
`timescale 1ns/100ps
module alu_branch_execute_bench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  reg         we_i  = 1'b0;
  reg  [11:0] adr_i = 12'h000;
  reg  [3:0]  sel_i = 4'hF;
  reg  [31:0] dat_i = 32'h0;
  wire [31:0] dat_o;
  wire        ack_o;
  integer     bad_count = 0;
  integer     tests_run = 0;
  integer     seed = 32'h1D7AAF26;
  integer     i;
  reg  [31:0] q;
  reg  [15:0] p, w, x, e;
  reg  [10:0] k;
  reg  [7:0]  a, b, s, v;
  reg  [5:0]  o, n;
  reg  [4:0]  d;
  reg  [2:0]  bt;
  reg  [1:0]  cy;
  reg         l, t, c, ov;

  abe_exec dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

  // ----------------------------------------------------------------
  // Clock, report and bus cycles
  // ----------------------------------------------------------------
  always #5 clk_i = ~clk_i;

  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [15:0] ex, input [15:0] sn);
    begin
      tests_run = tests_run + 1;
      if (sn !== ex) begin
        $display("BAD %s expected %h seen %h", nm, ex, sn);
        bad_count = bad_count + 1;
      end
    end
  endtask

  // Request held until ack is sampled, then released for a cycle
  task bus(input w_en, input [11:0] ad, input [31:0] wd);
    integer cnt;
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w_en;
      adr_i <= ad;
      dat_i <= wd;
      cnt = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && cnt < 40) begin
        @(posedge clk_i);
        cnt = cnt + 1;
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (cnt == 40) begin
        bad_count = bad_count + 1;
        summarize;
      end
    end
  endtask

  function [11:0] ga(input [5:0] r);
    ga = 12'h100 + {r, 2'b00};
  endfunction

  function [11:0] ia(input [5:0] r);
    ia = 12'h200 + {r, 2'b00};
  endfunction

  function [31:0] ow(input [5:0] op, input [4:0] rd, input [5:0] rr, input [2:0] bi, input lg, input [10:0] kk);
    ow = {kk, lg, bi, rr, rd, op};
  endfunction

  // Reference ALU: returns {flags, result}; S is left alone by byte ops
  function automatic [15:0] alu(input [5:0] op, input [7:0] ra, input [7:0] rb, input [7:0] sr);
    reg [8:0] tt;
    reg [7:0] f;
    reg       ci;
    begin
      f = sr;
      ci = (op == 6'h01 || op == 6'h04 || op == 6'h05 || op == 6'h10) ? sr[0] : 1'b0;
      if (op >= 6'h06 && op <= 6'h0C) begin
        case (op)
          6'h06, 6'h07: tt = ra & rb;
          6'h08, 6'h09: tt = ra | rb;
          6'h0A: tt = ra ^ rb;
          6'h0B: tt = ra & (8'hFF - rb);
          default: tt = ra & ra;
        endcase
        f[3] = 1'b0;
      end else if (op > 6'h01) begin
        tt = {1'b0, ra} - rb - ci;
        f[0] = tt[8];
        f[5] = {1'b0, ra[3:0]} < rb[3:0] + ci;
        f[3] = (ra[7] != rb[7]) && (tt[7] != ra[7]);
      end else begin
        tt = ra + rb + ci;
        f[0] = tt[8];
        f[5] = {1'b0, ra[3:0]} + rb[3:0] + ci > 5'h0F;
        f[3] = (ra[7] == rb[7]) && (tt[7] != ra[7]);
      end
      f[2] = tt[7];
      f[1] = tt[7:0] == 8'h00 && (op == 6'h04 || op == 6'h05 || op == 6'h10 ? sr[1] : 1'b1);
      alu = {f, tt[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 12'h004, 0);
    chk("pc", 0, q[15:0]);
    bus(1'b1, 12'h180, 32'h5A);
    bus(1'b0, 12'h180, 0);
    chk("hole", 0, q[15:0]);
    // Byte ALU ops, boundary operands first then random
    for (i = 0; i < 64; i = i + 1) begin
      o = (i % 16 < 13) ? i % 16 : i % 16 + 2;
      a = (i < 16) ? 8'h80 : $random(seed);
      b = (i < 16) ? 8'h01 : $random(seed);
      k = $random(seed);
      s = $random(seed);
      d = 16 + i % 8;
      bus(1'b1, ga(d), a);
      bus(1'b1, ga(d + 8), b);
      bus(1'b1, 12'h008, s);
      // Constant forms: odd codes below the compares except 0x01, plus the compare-immediate
      x = alu(o, a, (o[0] && o < 6'h0F && o != 6'h01) || o == 6'h11 ? k[7:0] : b, s);
      bus(1'b1, 12'h000, ow(o, d, d + 8, 0, 0, k));
      bus(1'b0, ga(d), 0);
      chk("dest", o >= 6'h0F ? a : x[7:0], q[7:0]);
      bus(1'b0, 12'h008, 0);
      chk("flags", x[15:8], q[7:0]);
      bus(1'b0, 12'h00C, 0);
      chk("cycles", 1, q[3:2]);
    end
    // Word immediate add and subtract on a pair
    for (i = 0; i < 8; i = i + 1) begin
      d = 24 + 2 * (i % 4);
      w = (i < 2) ? 16'h7FFF : $random(seed);
      k = $random(seed);
      s = $random(seed);
      bus(1'b1, ga(d), w[7:0]);
      bus(1'b1, ga(d + 1), w[15:8]);
      bus(1'b1, 12'h008, s);
      bus(1'b1, 12'h000, ow(6'h0D + i[0], d, 0, 0, 0, k));
      x = i[0] ? w - k[5:0] : w + k[5:0];
      c = i[0] ? k[5:0] > w : x < w;
      ov = i[0] ? w[15] & ~x[15] : ~w[15] & x[15];
      s[4:0] = {x[15] ^ ov, ov, x[15], x == 16'h0, c};
      bus(1'b0, ga(d + 1), 0);
      chk("word", x[15:8], q[7:0]);
      bus(1'b0, ga(d), 0);
      chk("word", x[7:0], q[7:0]);
      bus(1'b0, 12'h008, 0);
      chk("wflags", s, q[7:0]);
      bus(1'b0, 12'h00C, 0);
      chk("wcycles", 2, q[3:2]);
    end
    // Skips, jumps, calls and branches with random state
    for (i = 0; i < 76; i = i + 1) begin
      o = 6'h12 + i % 19;
      o = (o == 6'h17 || o == 6'h18) ? o - 6'h2 : o;
      p = $random(seed);
      a = $random(seed);
      b = (i < 19 || o == 6'h13 || o == 6'h14) ? a : $random(seed);
      s = $random(seed);
      k = (i < 19) ? 11'h400 : $random(seed);
      bt = $random(seed);
      l = $random(seed);
      n = $random(seed) & 31;
      bus(1'b1, ga(2), a);
      bus(1'b1, ga(3), b);
      bus(1'b1, ga(30), b);
      bus(1'b1, ga(31), a);
      bus(1'b1, ia(n), a);
      bus(1'b1, 12'h004, p);
      bus(1'b1, 12'h008, s);
      bus(1'b1, 12'h000, ow(o, 2, o == 6'h15 || o == 6'h16 ? n : 3, bt, l, k));
      case (o)
        6'h12: t = a == b;
        6'h13, 6'h15: t = !a[bt];
        6'h14, 6'h16: t = a[bt];
        6'h1D: t = s[bt];
        6'h1E: t = !s[bt];
        6'h1F: t = s[1];
        6'h20: t = !s[1];
        6'h21, 6'h24: t = s[0];
        6'h22, 6'h23: t = !s[0];
        default: t = 1'b1;
      endcase
      e = p + {{5{k[10]}}, k} + 16'h1;
      if (o < 6'h19) begin
        x = t ? p + 16'h2 + l : p + 16'h1;
        cy = t ? 2'd2 + l : 2'd1;
      end else if (o < 6'h1D) begin
        x = o > 6'h1A ? {a, b} : e;
        cy = o[0] ? 2'd2 : 2'd3;
      end else begin
        x = t ? e : p + 16'h1;
        cy = t ? 2'd2 : 2'd1;
      end
      bus(1'b0, 12'h004, 0);
      chk("pc", x, q[15:0]);
      bus(1'b0, 12'h008, 0);
      chk("sreg kept", s, q[7:0]);
      bus(1'b0, 12'h00C, 0);
      chk("cycles", cy, q[3:2]);
      if (o == 6'h1A || o == 6'h1C) begin
        bus(1'b0, 12'h010, 0);
        chk("ret", p + 16'h1, q[15:0]);
      end
    end
    // Single-bit I/O writes inside and outside the low range
    for (i = 0; i < 8; i = i + 1) begin
      n = (i < 4 ? 0 : 32) + i[1] * 31;
      v = $random(seed);
      bt = $random(seed);
      bus(1'b1, ia(n), v);
      bus(1'b1, 12'h000, ow(6'h17 + i[0], 0, n, bt, 0, 0));
      e = v;
      if (n < 32)
        e[bt] = !i[0];
      bus(1'b0, ia(n), 0);
      chk("io byte", e, q[7:0]);
      bus(1'b0, 12'h00C, 0);
      chk("bad", n > 31, q[5]);
    end
    bus(1'b1, 12'h004, 16'h1234);
    bus(1'b1, 12'h000, ow(6'h15, 0, 32, 0, 0, 0));
    bus(1'b0, 12'h004, 0);
    chk("pc", 16'h1234, q[15:0]);
    // Byte enables: only the upper PC byte moves
    sel_i <= 4'h2;
    bus(1'b1, 12'h004, 32'h0000ABCD);
    sel_i <= 4'hF;
    bus(1'b0, 12'h004, 0);
    chk("pc sel", 16'hAB34, q[15:0]);
    // Unknown opcode leaves PC alone and flags the command
    bus(1'b1, 12'h000, 32'h0000003F);
    bus(1'b0, 12'h004, 0);
    chk("pc bad op", 16'hAB34, q[15:0]);
    bus(1'b0, 12'h00C, 0);
    chk("bad op", 1, q[5]);
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, ga(2), 0);
    chk("gpr", 0, q[15:0]);
    bus(1'b0, 12'h00C, 0);
    chk("status", 0, q[15:0]);
    summarize;
  end
endmodule // alu_branch_execute_bench
